// ### hdl/pfp_fuse_programmer.v
// Pulse driven fuse programming state machine with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "pfp_fuse_regs.vh"

module pfp_fuse_programmer (
    // Clock and power-up reset
    input  wire        clk,
    input  wire        reset,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output reg         pslverr,
    // Comparator levels seen on the sensor output pin
    input  wire        mid_level_in,
    input  wire        high_level_in,
    // Parameters applied to the analog front end
    output reg  [7:0]  sens_code,
    output reg  [7:0]  fine_offset_code,
    output reg         unidirectional,
    output reg         locked,
    output reg         fuse_blow_pulse
);

    // Classified pin events
    wire       mid_level_pulse;   // One mid-level pulse ended
    wire       high_level_pulse;  // One high-level pulse ended

    // Programming logic state
    reg [2:0]  state_q;           // Programming state
    reg [2:0]  state_d;
    reg [7:0]  key_q;             // Register key within the zone
    reg [7:0]  key_d;
    reg [1:0]  sel_q;             // Register being addressed
    reg [1:0]  sel_d;

    // Temporary codes, volatile
    reg [7:0]  temp_sens_q;
    reg [7:0]  temp_fine_q;
    reg [7:0]  temp_shared_q;

    // Fuse array, cleared only by the reset input
    reg [7:0]  fuse_sens_q;
    reg [7:0]  fuse_fine_q;
    reg [7:0]  fuse_shared_q;

    // Control bits
    reg        pin_en_q;          // Pin events reach the state machine
    reg        pwr_cycle_q;       // One-cycle soft supply cycle

    // Bus strobes
    wire       setup_phase = psel & ~penable;
    wire       access_wr   = psel & penable & pwrite;
    wire       addr_known  = (paddr == `PFP_ADDR_CTRL)  | (paddr == `PFP_ADDR_STATUS) |
                             (paddr == `PFP_ADDR_TEMP)  | (paddr == `PFP_ADDR_FUSE)   |
                             (paddr == `PFP_ADDR_EFFECT);

    // Events gated by the pin enable and by the lock fuse
    wire       lock_fuse  = fuse_shared_q[`PFP_BIT_LOCK];
    wire       ev_mid     = mid_level_pulse & pin_en_q & ~lock_fuse;
    wire       ev_high    = high_level_pulse & pin_en_q & ~lock_fuse;

    // Power-up or soft supply cycle
    wire       power_up   = reset | pwr_cycle_q;

    // Temporary code of the addressed register
    reg  [7:0] sel_temp;

    // Pulse classifier on the output pin
    pfp_level_classifier u_classifier (
        .clk              (clk),
        .reset            (reset),
        .mid_level_in     (mid_level_in),
        .high_level_in    (high_level_in),
        .mid_level_pulse  (mid_level_pulse),
        .high_level_pulse (high_level_pulse)
    );

    // Pick the temporary code of the addressed register
    always @* begin
        case (sel_q)
            `PFP_SEL_SENS:   sel_temp = temp_sens_q;
            `PFP_SEL_FINE:   sel_temp = temp_fine_q;
            `PFP_SEL_SHARED: sel_temp = temp_shared_q;
            default:         sel_temp = `PFP_CODE_ZERO;
        endcase
    end

    // Next state of the programming sequence
    always @* begin
        state_d = state_q;
        key_d   = key_q;
        sel_d   = sel_q;
        case (state_q)
            `PFP_ST_INIT: begin
                if (ev_high) begin
                    state_d = `PFP_ST_Z1_SEL;
                    key_d   = `PFP_KEY_ZERO;
                end
            end
            `PFP_ST_Z1_SEL: begin
                if (ev_mid && key_q != `PFP_CODE_MAX) begin
                    key_d = key_q + `PFP_KEY_ONE;
                end else if (ev_high && key_q == `PFP_KEY_ZERO) begin
                    state_d = `PFP_ST_BYPASS;
                end else if (ev_high) begin
                    state_d = `PFP_ST_ADDR;
                    sel_d   = (key_q == `PFP_KEY_ONE) ? `PFP_SEL_SENS : `PFP_SEL_NONE;
                end
            end
            `PFP_ST_BYPASS: begin
                if (ev_high) begin
                    state_d = `PFP_ST_Z2_SEL;
                    key_d   = `PFP_KEY_ZERO;
                end
            end
            `PFP_ST_Z2_SEL: begin
                if (ev_mid && key_q != `PFP_CODE_MAX) begin
                    key_d = key_q + `PFP_KEY_ONE;
                end else if (ev_high) begin
                    state_d = `PFP_ST_ADDR;
                    if (key_q == `PFP_KEY_ONE) begin
                        sel_d = `PFP_SEL_FINE;
                    end else if (key_q == `PFP_KEY_TWO) begin
                        sel_d = `PFP_SEL_SHARED;
                    end else begin
                        sel_d = `PFP_SEL_NONE;
                    end
                end
            end
            `PFP_ST_ADDR: begin
                if (ev_high) begin
                    state_d = `PFP_ST_BLOWN;
                end
            end
            `PFP_ST_BLOWN: begin
                // Waits here for the supply to cycle
                state_d = `PFP_ST_BLOWN;
            end
            default: begin
                state_d = `PFP_ST_INIT;
            end
        endcase
    end

    // State registers
    always @(posedge clk) begin
        if (power_up) begin
            state_q <= `PFP_ST_INIT;
            key_q   <= `PFP_KEY_ZERO;
            sel_q   <= `PFP_SEL_NONE;
        end else begin
            state_q <= state_d;
            key_q   <= key_d;
            sel_q   <= sel_d;
        end
    end

    // Temporary codes
    always @(posedge clk) begin
        if (power_up) begin
            temp_sens_q   <= `PFP_CODE_ZERO;
            temp_fine_q   <= `PFP_CODE_ZERO;
            temp_shared_q <= `PFP_CODE_ZERO;
        end else if (state_q == `PFP_ST_ADDR && ev_mid && sel_temp != `PFP_CODE_MAX) begin
            case (sel_q)
                `PFP_SEL_SENS:   temp_sens_q   <= temp_sens_q + `PFP_CODE_ONE;
                `PFP_SEL_FINE:   temp_fine_q   <= temp_fine_q + `PFP_CODE_ONE;
                `PFP_SEL_SHARED: temp_shared_q <= temp_shared_q + `PFP_CODE_ONE;
                default:         temp_sens_q   <= temp_sens_q;
            endcase
        end
    end

    // Fuse array, survives soft supply cycles
    always @(posedge clk) begin
        if (reset) begin
            fuse_sens_q     <= `PFP_CODE_ZERO;
            fuse_fine_q     <= `PFP_CODE_ZERO;
            fuse_shared_q   <= `PFP_CODE_ZERO;
            fuse_blow_pulse <= 1'b0;
        end else begin
            fuse_blow_pulse <= 1'b0;
            if (!pwr_cycle_q && state_q == `PFP_ST_ADDR && ev_high) begin
                fuse_blow_pulse <= (sel_q != `PFP_SEL_NONE);
                case (sel_q)
                    `PFP_SEL_SENS:   fuse_sens_q   <= fuse_sens_q | temp_sens_q;
                    `PFP_SEL_FINE:   fuse_fine_q   <= fuse_fine_q | temp_fine_q;
                    `PFP_SEL_SHARED: fuse_shared_q <= fuse_shared_q | temp_shared_q;
                    default:         fuse_sens_q   <= fuse_sens_q;
                endcase
            end
        end
    end

    // Applied parameters: blown bits plus temporary code; locked from the lock fuse alone
    always @(posedge clk) begin
        if (reset) begin
            sens_code        <= `PFP_CODE_ZERO;
            fine_offset_code <= `PFP_CODE_ZERO;
            unidirectional   <= 1'b0;
            locked           <= 1'b0;
        end else begin
            sens_code        <= fuse_sens_q | temp_sens_q;
            fine_offset_code <= fuse_fine_q | temp_fine_q;
            unidirectional   <= fuse_shared_q[`PFP_BIT_UNIDIR] | temp_shared_q[`PFP_BIT_UNIDIR];
            locked           <= lock_fuse;
        end
    end

    // Control register and soft supply cycle strobe
    always @(posedge clk) begin
        if (reset) begin
            pin_en_q    <= `PFP_CTRL_RESET;
            pwr_cycle_q <= 1'b0;
        end else begin
            pwr_cycle_q <= 1'b0;
            if (access_wr && paddr == `PFP_ADDR_CTRL) begin
                pin_en_q    <= pwdata[`PFP_CTRL_PIN_EN];
                pwr_cycle_q <= pwdata[`PFP_CTRL_PWR_CYCLE];
            end
        end
    end

    // Zero wait states
    assign pready = psel & penable;

    // Read data and error captured in the setup cycle
    always @(posedge clk) begin
        if (reset) begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata  <= 32'h0;
            pslverr <= ~addr_known;
            if (!pwrite) begin
                case (paddr)
                    `PFP_ADDR_CTRL: begin
                        prdata[`PFP_CTRL_PIN_EN] <= pin_en_q;
                    end
                    `PFP_ADDR_STATUS: begin
                        prdata[`PFP_STAT_STATE_LSB +: 3] <= state_q;
                        prdata[`PFP_STAT_SEL_LSB +: 2]   <= sel_q;
                        prdata[`PFP_STAT_KEY_LSB +: 8]   <= key_q;
                        prdata[`PFP_STAT_LOCK_BIT]       <= lock_fuse;
                        prdata[`PFP_STAT_PEN_BIT]        <= pin_en_q;
                    end
                    `PFP_ADDR_TEMP: begin
                        prdata[`PFP_SENS_LSB +: 8]   <= temp_sens_q;
                        prdata[`PFP_FINE_LSB +: 8]   <= temp_fine_q;
                        prdata[`PFP_SHARED_LSB +: 8] <= temp_shared_q;
                    end
                    `PFP_ADDR_FUSE: begin
                        prdata[`PFP_SENS_LSB +: 8]   <= fuse_sens_q;
                        prdata[`PFP_FINE_LSB +: 8]   <= fuse_fine_q;
                        prdata[`PFP_SHARED_LSB +: 8] <= fuse_shared_q;
                    end
                    `PFP_ADDR_EFFECT: begin
                        prdata[`PFP_SENS_LSB +: 8]   <= fuse_sens_q | temp_sens_q;
                        prdata[`PFP_FINE_LSB +: 8]   <= fuse_fine_q | temp_fine_q;
                        prdata[`PFP_SHARED_LSB +: 8] <= fuse_shared_q | temp_shared_q;
                    end
                    default: begin
                        prdata <= 32'h0;
                    end
                endcase
            end
        end
    end

endmodule // pfp_fuse_programmer

`default_nettype wire

// ### hdl/pfp_fuse_regs.vh
// Register map, field layout and encodings of the pulse driven fuse programmer
`ifndef PFP_FUSE_REGS_VH
`define PFP_FUSE_REGS_VH

// APB byte addresses
`define PFP_ADDR_CTRL        8'h00
`define PFP_ADDR_STATUS      8'h04
`define PFP_ADDR_TEMP        8'h08
`define PFP_ADDR_FUSE        8'h0c
`define PFP_ADDR_EFFECT      8'h10

// Control register fields
`define PFP_CTRL_PWR_CYCLE   0
`define PFP_CTRL_PIN_EN      1
`define PFP_CTRL_RESET       1'b0

// Packed layout of the three 8-bit parameter bytes
`define PFP_SENS_LSB         0
`define PFP_FINE_LSB         8
`define PFP_SHARED_LSB       16

// Status register layout
`define PFP_STAT_STATE_LSB   0
`define PFP_STAT_SEL_LSB     4
`define PFP_STAT_KEY_LSB     8
`define PFP_STAT_LOCK_BIT    16
`define PFP_STAT_PEN_BIT     17

// Code field values
`define PFP_CODE_ZERO        8'h00
`define PFP_CODE_MAX         8'hff
`define PFP_CODE_ONE         8'h01
`define PFP_BIT_UNIDIR       0
`define PFP_BIT_LOCK         2

// Register keys
`define PFP_KEY_ZERO         8'h00
`define PFP_KEY_ONE          8'h01
`define PFP_KEY_TWO          8'h02

// Selected parameter register
`define PFP_SEL_NONE         2'h0
`define PFP_SEL_SENS         2'h1
`define PFP_SEL_FINE         2'h2
`define PFP_SEL_SHARED       2'h3

// Programming states
`define PFP_ST_INIT          3'h0
`define PFP_ST_Z1_SEL        3'h1
`define PFP_ST_BYPASS        3'h2
`define PFP_ST_Z2_SEL        3'h3
`define PFP_ST_ADDR          3'h4
`define PFP_ST_BLOWN         3'h5

`endif

// ### hdl/pfp_level_classifier.v
// Turns the two pin level comparators into one mid or high event per pulse
`timescale 1ns/1ps
`default_nettype none

module pfp_level_classifier (
    // Clock and reset
    input  wire clk,
    input  wire reset,
    // Comparator levels from the output pin
    input  wire mid_level_in,
    input  wire high_level_in,
    // One-cycle events, issued at the pulse's trailing edge
    output reg  mid_level_pulse,
    output reg  high_level_pulse
);

    reg [1:0] mid_sync_q;   // Two-flop synchroniser, mid comparator
    reg [1:0] high_sync_q;  // Two-flop synchroniser, high comparator
    reg       in_pulse_q;   // A pulse is in progress
    reg       saw_high_q;   // The pulse reached the high level

    wire pin_up = mid_sync_q[1] | high_sync_q[1];

    // Synchronise both comparator levels
    always @(posedge clk) begin
        if (reset) begin
            mid_sync_q  <= 2'h0;
            high_sync_q <= 2'h0;
        end else begin
            mid_sync_q  <= {mid_sync_q[0], mid_level_in};
            high_sync_q <= {high_sync_q[0], high_level_in};
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            in_pulse_q       <= 1'b0;
            saw_high_q       <= 1'b0;
            mid_level_pulse  <= 1'b0;
            high_level_pulse <= 1'b0;
        end else begin
            in_pulse_q       <= pin_up;
            mid_level_pulse  <= 1'b0;
            high_level_pulse <= 1'b0;
            if (pin_up) begin
                // Remember the peak level while the pulse lasts
                saw_high_q <= saw_high_q | high_sync_q[1];
            end else if (in_pulse_q) begin
                // Trailing edge: classify by the peak seen
                mid_level_pulse  <= ~saw_high_q;
                high_level_pulse <= saw_high_q;
                saw_high_q       <= 1'b0;
            end
        end
    end

endmodule // pfp_level_classifier

`default_nettype wire

// ### sim/pfp_fuse_props.sv
// Concurrent checks on the fuse programmer ports
`timescale 1ns/1ps
`default_nettype none
module pfp_fuse_props (
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Pin levels and applied parameters
    input wire logic        mid_level_in,
    input wire logic        high_level_in,
    input wire logic [7:0]  sens_code,
    input wire logic [7:0]  fine_offset_code,
    input wire logic        unidirectional,
    input wire logic        locked,
    input wire logic        fuse_blow_pulse
);
    logic [7:0] pin_q, wr_q, hi_q, blow_q; // Cycles since pin, write, high, blow

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Saturating age counters, parked at the top during reset
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_q  <= 8'hff;
            wr_q   <= 8'hff;
            hi_q   <= 8'hff;
            blow_q <= 8'hff;
        end else begin
            pin_q  <= (mid_level_in | high_level_in) ? 8'h00 : pin_q + {7'h0, pin_q != 8'hff};
            wr_q   <= (psel & penable & pwrite) ? 8'h00 : wr_q + {7'h0, wr_q != 8'hff};
            hi_q   <= high_level_in ? 8'h00 : hi_q + {7'h0, hi_q != 8'hff};
            blow_q <= fuse_blow_pulse ? 8'h00 : blow_q + {7'h0, blow_q != 8'hff};
        end
    end

    chk_reset_clear: assert property (disable iff (1'b0) reset |=> sens_code == 8'h00
        && fine_offset_code == 8'h00 && !unidirectional && !locked && !fuse_blow_pulse)
        else $error("outputs not cleared by reset");
    chk_blow_single: assert property (fuse_blow_pulse |=> !fuse_blow_pulse)
        else $error("blow pulse longer than one cycle");
    chk_blow_high: assert property (fuse_blow_pulse |-> hi_q < 8'd12)
        else $error("blow without a recent high pulse");
    chk_hold_quiet: assert property ($changed(sens_code) || $changed(fine_offset_code)
        || $changed(unidirectional) |-> pin_q < 8'd12 || wr_q < 8'd6)
        else $error("applied code changed with no cause");
    chk_lock_sticky: assert property (locked |=> locked)
        else $error("lock released");
    chk_lock_frozen: assert property (locked && wr_q > 8'd4 |=> $stable(sens_code)
        && $stable(fine_offset_code) && $stable(unidirectional))
        else $error("code changed while locked");
    chk_lock_blow: assert property ($rose(locked) |-> fuse_blow_pulse || blow_q < 8'd3)
        else $error("lock set without a blow");
    chk_ready_access: assert property (pready == (psel && penable))
        else $error("pready not zero wait");
    chk_unmapped_err: assert property (psel && !penable && paddr > 8'h10 |=> pslverr && prdata == 32'h0)
        else $error("unmapped access without error");

    cov_blow: cover property (fuse_blow_pulse);
    cov_lock: cover property ($rose(locked));
    cov_unidir: cover property ($rose(unidirectional));
    cov_sat: cover property (sens_code == 8'hff);
endmodule // pfp_fuse_props

bind pfp_fuse_programmer pfp_fuse_props u_props (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .mid_level_in(mid_level_in), .high_level_in(high_level_in), .sens_code(sens_code),
    .fine_offset_code(fine_offset_code), .unidirectional(unidirectional), .locked(locked),
    .fuse_blow_pulse(fuse_blow_pulse));
`default_nettype wire

// ### sim/pfp_station_model.sv
// Programming station model driving pulses onto the output pin comparators
`timescale 1ns/1ps
`default_nettype none
module pfp_station_model (
    // Clock
    input  wire logic clk,
    // Comparator levels of the pin
    output var logic  mid_level_in,
    output var logic  high_level_in
);
    // Pin rests below both thresholds
    initial begin
        mid_level_in = 1'b0;
        high_level_in = 1'b0;
    end

    task automatic pulse(input logic hi);
        begin
            @(posedge clk);
            mid_level_in <= 1'b1;
            high_level_in <= hi;
            repeat (4) @(posedge clk);
            mid_level_in <= 1'b0;
            high_level_in <= 1'b0;
            // Long low gap so the event has landed before the next pulse
            repeat (8) @(posedge clk);
        end
    endtask
endmodule // pfp_station_model
`default_nettype wire

// ### sim/test_pulse_driven_fuse_programmer.sv
// Directed bench for the pulse driven fuse programmer
`timescale 1ns/1ps
`default_nettype none
`include "pfp_fuse_regs.vh"
module test_pulse_driven_fuse_programmer;
    logic        clk, reset, psel, penable, pwrite; // Clock, reset, APB controls
    logic [7:0]  paddr;                             // APB address
    logic [31:0] pwdata, rd;                        // Write data, last read
    logic        err;                               // Last error flag
    wire  [31:0] prdata;                            // Read data
    wire         pready, pslverr;                   // APB answer
    wire         mid_level_in, high_level_in;       // Pin comparators
    wire  [7:0]  sens_code, fine_offset_code;       // Applied codes
    wire         unidirectional, locked, fuse_blow_pulse; // Applied flags
    integer      n_fail, check_count, cyc, blows, i; // Counters

    pfp_station_model station (.clk(clk), .mid_level_in(mid_level_in), .high_level_in(high_level_in));
    pfp_fuse_programmer dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .mid_level_in(mid_level_in), .high_level_in(high_level_in), .sens_code(sens_code),
        .fine_offset_code(fine_offset_code), .unidirectional(unidirectional), .locked(locked),
        .fuse_blow_pulse(fuse_blow_pulse));

    initial clk = 1'b0;
    always #2 clk = ~clk;

    // Watchdog and blow pulse counter
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (fuse_blow_pulse === 1'b1) begin
            blows <= blows + 1;
        end
        if (cyc == 30000) begin
            n_fail = n_fail + 1;
            report_and_stop;
        end
    end

    task automatic report_and_stop;
        begin
            $display("checks %0d mismatches %0d", check_count, n_fail);
            if (n_fail == 0 && check_count > 0) begin
                $display("Finished cleanly");
            end else begin
                $display("Finished with errors");
            end
            $finish;
        end
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        begin
            @(posedge clk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            @(posedge clk);
            while (pready !== 1'b1) @(posedge clk);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // Compare the state field of STATUS
    task automatic st(input logic [2:0] s);
        begin
            apb(1'b0, `PFP_ADDR_STATUS, 32'h0);
            chk({29'h0, rd[2:0]}, {29'h0, s});
        end
    endtask

    // Pulse string: H high level, M mid level
    task automatic send(input string s);
        begin
            for (int k = 0; k < s.len(); k++) begin
                station.pulse(s[k] == "H");
            end
        end
    endtask

    // Soft supply cycle keeping the pin enabled; waits until the applied codes have settled
    task automatic pcyc;
        begin
            apb(1'b1, `PFP_ADDR_CTRL, 32'h3);
            repeat (3) @(posedge clk);
        end
    endtask

    initial begin
        {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        {n_fail, check_count, cyc, blows} = 128'h0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        for (i = 0; i < 5; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk(rd, 32'h0);
        end
        chk({24'h0, sens_code}, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        // Refused while disabled, then mid pulses ignored at start
        send("H");
        st(`PFP_ST_INIT);
        apb(1'b1, `PFP_ADDR_CTRL, 32'h2);
        send("MM");
        st(`PFP_ST_INIT);
        send("HM");
        apb(1'b0, `PFP_ADDR_STATUS, 32'h0);
        chk({16'h0, rd[15:0]}, 32'h0101);
        send("H");
        st(`PFP_ST_ADDR);
        chk({30'h0, rd[5:4]}, {30'h0, `PFP_SEL_SENS});
        for (i = 0; i < 260; i++) send("M");
        repeat (40) @(posedge clk);
        chk({24'h0, sens_code}, 32'hff);
        apb(1'b0, `PFP_ADDR_FUSE, 32'h0);
        chk(rd, 32'h0);
        pcyc;
        chk({24'h0, sens_code}, 32'h0);
        send("HMHMMH");
        chk(blows, 1);
        send("M");
        st(`PFP_ST_BLOWN);
        pcyc;
        chk({24'h0, sens_code}, 32'h2);
        send("HHM");
        apb(1'b0, `PFP_ADDR_STATUS, 32'h0);
        chk({16'h0, rd[15:0]}, 32'h0002);
        send("H");
        st(`PFP_ST_Z2_SEL);
        send("MH");
        st(`PFP_ST_ADDR);
        chk({30'h0, rd[5:4]}, {30'h0, `PFP_SEL_FINE});
        send("MMMMM");
        chk({24'h0, fine_offset_code}, 32'h5);
        apb(1'b0, `PFP_ADDR_EFFECT, 32'h0);
        chk(rd, 32'h00000502);
        pcyc;
        send("HHHMMHMH");
        pcyc;
        chk({31'h0, unidirectional}, 32'h1);
        send("HHHMMHMMMMH");
        pcyc;
        chk({31'h0, locked}, 32'h1);
        send("HMHMMM");
        chk({24'h0, sens_code}, 32'h2);
        st(`PFP_ST_INIT);
        report_and_stop;
    end
endmodule // test_pulse_driven_fuse_programmer
`default_nettype wire
